// >>> core/dca_pkg.sv
// Purpose: shared constants, states and carriers of the dma address/count/status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   per-channel registers repeat every 16 bytes
package dca_pkg;
  localparam int         NCH          = 8;
  localparam int         COUNT_W      = 10;
  localparam logic [3:0] OFF_CTRL     = 4'h0;
  localparam logic [3:0] OFF_PADDR    = 4'h4;
  localparam logic [3:0] OFF_COUNT    = 4'h8;
  localparam logic [3:0] OFF_BASES    = 4'hc;
  localparam logic [7:0] OFF_COLL     = 8'h80;
  localparam logic [7:0] OFF_ACT      = 8'h84;
  localparam logic [7:0] OFF_RECENT   = 8'h88;
  localparam logic [7:0] OFF_ISTAT    = 8'h8c;
  localparam logic [7:0] OFF_IMASK    = 8'h90;
  localparam int         CTRL_ON_BIT  = 15;
  localparam int         CTRL_DIR_BIT = 13;
  localparam int         CTRL_HALF_BIT = 12;
  localparam int         CTRL_MODE_LSB = 0;
  localparam int         COLL_PER_LSB = 8;
  localparam int         COLL_RAM_LSB = 0;
  localparam int         ACT_LAST_LSB = 8;
  localparam int         ACT_PP_LSB   = 0;
  localparam logic [3:0] LAST_NONE    = 4'hf;
  localparam logic [15:0] ADDR_RST    = 16'h0000;
  localparam logic [15:0] RAM_STEP    = 16'h0002;

  typedef enum logic [2:0] {
    DCA_IDLE = 3'b001,
    DCA_RD   = 3'b010,
    DCA_WR   = 3'b100
  } dca_fsm_e;

  // one data-mover access: ram=1 targets dma ram, ram=0 the peripheral space
  typedef struct packed {
    logic        en;
    logic        ram;
    logic [15:0] addr;
    logic [15:0] data;
  } dca_port_s;

  // software write seen on the cpu side of the same ram/peripheral space
  typedef struct packed {
    logic        wr;
    logic        ram;
    logic [15:0] addr;
  } dca_cpu_s;

  // mode[1] ping-pong, mode[0] one-shot
  typedef struct packed {
    logic       channel_on;
    logic       dir;
    logic       half;
    logic [1:0] mode;
  } dca_ctrl_s;
endpackage

// >>> core/dca_apb.sv
// Purpose: apb slave front with no wait states
// Assumes: decode and read mux come from the register owner
// Notes:   read data is latched in the setup cycle so prdata is a flop
module dca_apb (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic        hit,
  input  logic [31:0] rdata,
  output logic        pready,
  output logic        pslverr,
  output logic [31:0] prdata,
  output logic        wr_fire
);
  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } dca_apb_s;

  dca_apb_s st_reg;
  dca_apb_s st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.ready = psel & ~penable;
    st_next.err   = psel & ~penable & ~hit;
    st_next.rdata = (psel & ~penable & ~pwrite & hit) ? rdata : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // unmapped writes are dropped, the error answer tells software
  assign wr_fire = psel & penable & pwrite & st_reg.ready & ~st_reg.err;
  assign pready  = st_reg.ready;
  assign pslverr = st_reg.err;
  assign prdata  = st_reg.rdata;
endmodule // dca_apb

// >>> core/dca_arb.sv
// Purpose: fixed-priority pick of one pending channel
// Assumes: lowest channel number wins
// Notes:   pure logic, no state
module dca_arb #(
  parameter int N = dca_pkg::NCH
) (
  input  logic [N-1:0] req,
  output logic [N-1:0] gnt,
  output logic [2:0]   gnt_idx,
  output logic         any
);
  logic [N:0] below;

  // the index output is three bits wide
  if (N < 1 || N > 8) begin : g_chk
    $error("N must be 1 to 8");
  end

  assign below[0] = 1'b0;
  for (genvar i = 0; i < N; i++) begin : g_pri
    assign below[i+1] = below[i] | req[i];
    assign gnt[i]     = req[i] & ~below[i];
  end
  assign any = below[N];

  always_comb begin
    gnt_idx = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (gnt[i]) begin
        gnt_idx = 3'(i);
      end
    end
  end
endmodule // dca_arb

// >>> core/dca_core.sv
// Purpose: address, count and shared status of an eight-channel dma mover
// Assumes: apb register access; ram and peripheral reads return data in the read cycle
// Notes:   one transfer takes three cycles: pick, read, write
//
// Implementation choices: the placing of the registers and the APB slave port.
module dca_core #(
  parameter int NCH = dca_pkg::NCH
) (
  input  logic                pclk,
  input  logic                presetn,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [7:0]          paddr,
  input  logic [31:0]         pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  logic [NCH-1:0]      dma_req,
  input  logic [15:0]         rd_data,
  input  dca_pkg::dca_cpu_s   cpu,
  output dca_pkg::dca_port_s  rd_port,
  output dca_pkg::dca_port_s  wr_port,
  output logic                irq
);
  if (NCH < 1 || NCH > 8) begin : g_chk
    $error("NCH must be 1 to 8");
  end

  typedef struct packed {
    dca_pkg::dca_fsm_e                       fsm;
    logic [2:0]                              cur;
    dca_pkg::dca_ctrl_s [NCH-1:0]            ctrl;
    logic [NCH-1:0][15:0]                    paddr;
    logic [NCH-1:0][15:0]                    primary_buffer_base;
    logic [NCH-1:0][15:0]                    stb;
    logic [NCH-1:0][dca_pkg::COUNT_W-1:0]    count;
    logic [NCH-1:0][dca_pkg::COUNT_W-1:0]    idx;
    logic [NCH-1:0]                          pingpong_buffer_select;
    logic [NCH-1:0]                          pend;
    logic [NCH-1:0]                          pcoll;
    logic [NCH-1:0]                          rcoll;
    logic [NCH-1:0]                          istat;
    logic [NCH-1:0]                          imask;
    logic [3:0]                              last;
    logic [15:0]                             recent;
    dca_pkg::dca_port_s                      rd;
    dca_pkg::dca_port_s                      wr;
    logic                                    irq;
  } dca_core_s;

  localparam dca_core_s RST = '{
    fsm:     dca_pkg::DCA_IDLE,
    last:    dca_pkg::LAST_NONE,
    recent:  dca_pkg::ADDR_RST,
    default: '0
  };

  dca_core_s      st_reg;
  dca_core_s      st_next;
  logic [2:0]     wch;
  logic           ch_ok;
  logic           hit;
  logic           wr_fire;
  logic [31:0]    rdata;
  logic [NCH-1:0] arb_req;
  logic [NCH-1:0] gnt;
  logic [2:0]     gidx;
  logic           gany;
  logic [NCH-1:0] on_vec;
  logic [NCH-1:0] cur_oh;
  logic [NCH-1:0] set_pc;
  logic [NCH-1:0] set_rc;
  logic [NCH-1:0] set_done;
  logic [NCH-1:0] clr_pc;
  logic [NCH-1:0] clr_rc;
  logic [NCH-1:0] clr_done;
  logic           blk_end;
  logic           clash;

  function automatic logic [15:0] ram_addr(input logic [15:0] base,
                                           input logic [dca_pkg::COUNT_W-1:0] i);
    ram_addr = 16'(base + 16'(16'(i) * dca_pkg::RAM_STEP));
  endfunction

  function automatic logic [31:0] ctrl_word(input dca_pkg::dca_ctrl_s c);
    logic [31:0] w;
    w = 32'h0;
    w[dca_pkg::CTRL_ON_BIT]   = c.channel_on;
    w[dca_pkg::CTRL_DIR_BIT]  = c.dir;
    w[dca_pkg::CTRL_HALF_BIT] = c.half;
    w[dca_pkg::CTRL_MODE_LSB +: 2] = c.mode;
    ctrl_word = w;
  endfunction

  assign wch   = paddr[6:4];
  assign ch_ok = ~paddr[7] && (paddr[1:0] == 2'h0) && (int'(wch) < NCH);
  assign hit   = ch_ok || paddr == dca_pkg::OFF_COLL || paddr == dca_pkg::OFF_ACT
                 || paddr == dca_pkg::OFF_RECENT || paddr == dca_pkg::OFF_ISTAT
                 || paddr == dca_pkg::OFF_IMASK;

  dca_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .hit     (hit),
    .rdata   (rdata),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .wr_fire (wr_fire)
  );

  for (genvar c = 0; c < NCH; c++) begin : g_on
    assign on_vec[c] = st_reg.ctrl[c].channel_on;
    assign cur_oh[c] = (st_reg.cur == 3'(c));
  end

  // the mover only asks for a new pick while idle
  assign arb_req = st_reg.pend & on_vec & {NCH{st_reg.fsm == dca_pkg::DCA_IDLE}};

  dca_arb #(.N(NCH)) u_arb (
    .req     (arb_req),
    .gnt     (gnt),
    .gnt_idx (gidx),
    .any     (gany)
  );

  assign blk_end = st_reg.fsm == dca_pkg::DCA_WR && st_reg.idx[st_reg.cur] == st_reg.count[st_reg.cur];
  assign clash   = st_reg.fsm == dca_pkg::DCA_WR && cpu.wr && cpu.ram == st_reg.wr.ram
                   && cpu.addr == st_reg.wr.addr;

  // read mux
  always_comb begin
    rdata = 32'h0;
    if (ch_ok) begin
      case (paddr[3:0])
        dca_pkg::OFF_CTRL:  rdata = ctrl_word(st_reg.ctrl[wch]);
        dca_pkg::OFF_PADDR: rdata = {16'h0, st_reg.paddr[wch]};
        dca_pkg::OFF_COUNT: rdata = {22'h0, st_reg.count[wch]};
        dca_pkg::OFF_BASES: rdata = {st_reg.stb[wch], st_reg.primary_buffer_base[wch]};
        default:            rdata = 32'h0;
      endcase
    end else begin
      case (paddr)
        dca_pkg::OFF_COLL:   rdata = {16'h0, 8'(st_reg.pcoll), 8'(st_reg.rcoll)};
        dca_pkg::OFF_ACT:    rdata = {16'h0, 4'h0, st_reg.last, 8'(st_reg.pingpong_buffer_select)};
        dca_pkg::OFF_RECENT: rdata = {16'h0, st_reg.recent};
        dca_pkg::OFF_ISTAT:  rdata = {24'h0, 8'(st_reg.istat)};
        dca_pkg::OFF_IMASK:  rdata = {24'h0, 8'(st_reg.imask)};
        default:             rdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    st_next  = st_reg;
    st_next.rd.en = 1'b0;
    st_next.wr.en = 1'b0;
    set_pc   = '0;
    set_rc   = '0;
    set_done = '0;
    clr_pc   = '0;
    clr_rc   = '0;
    clr_done = '0;

    // mover
    unique case (st_reg.fsm)
      dca_pkg::DCA_IDLE: begin
        if (gany) begin
          st_next.cur     = gidx;
          st_next.fsm     = dca_pkg::DCA_RD;
          st_next.rd.en   = 1'b1;
          st_next.rd.ram  = st_reg.ctrl[gidx].dir;
          st_next.rd.addr = st_reg.ctrl[gidx].dir
                            ? ram_addr(st_reg.pingpong_buffer_select[gidx] ? st_reg.stb[gidx] : st_reg.primary_buffer_base[gidx], st_reg.idx[gidx])
                            : st_reg.paddr[gidx];
          st_next.rd.data = 16'h0;
        end
      end
      dca_pkg::DCA_RD: begin
        st_next.fsm     = dca_pkg::DCA_WR;
        st_next.wr.en   = 1'b1;
        st_next.wr.ram  = ~st_reg.rd.ram;
        st_next.wr.addr = st_reg.rd.ram
                          ? st_reg.paddr[st_reg.cur]
                          : ram_addr(st_reg.pingpong_buffer_select[st_reg.cur] ? st_reg.stb[st_reg.cur] : st_reg.primary_buffer_base[st_reg.cur],
                                     st_reg.idx[st_reg.cur]);
        st_next.wr.data = rd_data;
      end
      dca_pkg::DCA_WR: begin
        st_next.fsm    = dca_pkg::DCA_IDLE;
        st_next.last   = {1'b0, st_reg.cur};
        st_next.recent = st_reg.wr.ram ? st_reg.wr.addr : st_reg.rd.addr;
        if (clash) begin
          set_pc = cur_oh & {NCH{~st_reg.wr.ram}};
          set_rc = cur_oh & {NCH{st_reg.wr.ram}};
        end
        if (st_reg.ctrl[st_reg.cur].half
            && st_reg.idx[st_reg.cur] == (st_reg.count[st_reg.cur] >> 1)) begin
          set_done = cur_oh;
        end
        if (blk_end) begin
          st_next.idx[st_reg.cur] = '0;
          if (!st_reg.ctrl[st_reg.cur].half) begin
            set_done = cur_oh;
          end
          if (st_reg.ctrl[st_reg.cur].mode[1]) begin
            st_next.pingpong_buffer_select[st_reg.cur] = ~st_reg.pingpong_buffer_select[st_reg.cur];
          end
          // one-shot ping-pong stops only after the secondary buffer is filled
          if (st_reg.ctrl[st_reg.cur].mode[0]
              && (!st_reg.ctrl[st_reg.cur].mode[1] || st_reg.pingpong_buffer_select[st_reg.cur])) begin
            st_next.ctrl[st_reg.cur].channel_on = 1'b0;
          end
        end else begin
          st_next.idx[st_reg.cur] = 10'(st_reg.idx[st_reg.cur] + 10'h1);
        end
      end
    endcase

    // software writes follow the mover so a write to ctrl wins over the one-shot stop
    if (wr_fire) begin
      if (ch_ok) begin
        case (paddr[3:0])
          dca_pkg::OFF_CTRL: begin
            st_next.ctrl[wch].channel_on = pwdata[dca_pkg::CTRL_ON_BIT];
            st_next.ctrl[wch].dir        = pwdata[dca_pkg::CTRL_DIR_BIT];
            st_next.ctrl[wch].half       = pwdata[dca_pkg::CTRL_HALF_BIT];
            st_next.ctrl[wch].mode       = pwdata[dca_pkg::CTRL_MODE_LSB +: 2];
            // turning a channel on restarts its block from the primary buffer
            if (!st_reg.ctrl[wch].channel_on && pwdata[dca_pkg::CTRL_ON_BIT]) begin
              st_next.idx[wch]  = '0;
              st_next.pingpong_buffer_select[wch] = 1'b0;
            end
          end
          dca_pkg::OFF_PADDR: st_next.paddr[wch] = pwdata[15:0];
          dca_pkg::OFF_COUNT: st_next.count[wch] = pwdata[dca_pkg::COUNT_W-1:0];
          dca_pkg::OFF_BASES: begin
            st_next.primary_buffer_base[wch] = pwdata[15:0];
            st_next.stb[wch] = pwdata[31:16];
          end
          default: st_next.primary_buffer_base[wch] = st_reg.primary_buffer_base[wch];
        endcase
      end else begin
        case (paddr)
          dca_pkg::OFF_COLL: begin
            clr_pc = NCH'(pwdata[dca_pkg::COLL_PER_LSB +: 8]);
            clr_rc = NCH'(pwdata[dca_pkg::COLL_RAM_LSB +: 8]);
          end
          dca_pkg::OFF_ISTAT: clr_done = NCH'(pwdata[7:0]);
          dca_pkg::OFF_IMASK: st_next.imask = NCH'(pwdata[7:0]);
          default:            st_next.imask = st_reg.imask;
        endcase
      end
    end

    // a request arriving in its grant cycle stays pending
    st_next.pend  = (st_reg.pend & ~gnt) | (dma_req & on_vec);
    // hardware set beats a write-one-to-clear in the same cycle
    st_next.pcoll = (st_reg.pcoll & ~clr_pc) | set_pc;
    st_next.rcoll = (st_reg.rcoll & ~clr_rc) | set_rc;
    st_next.istat = (st_reg.istat & ~clr_done) | set_done;
    st_next.irq   = |(st_next.istat & st_next.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_port = st_reg.rd;
  assign wr_port = st_reg.wr;
  assign irq     = st_reg.irq;

  sequence s_rd_phase;
    st_reg.rd.en;
  endsequence

  sequence s_wr_opposite;
    st_reg.wr.en && (st_reg.wr.ram != $past(st_reg.rd.ram));
  endsequence

  property p_pad_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && ch_ok && paddr[3:0] == dca_pkg::OFF_PADDR)
      |=> st_reg.paddr[$past(wch)] == $past(pwdata[15:0]);
  endproperty
  a_pad_write: assert property (p_pad_write) else $error("address write lost");

  property p_count_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && ch_ok && paddr[3:0] == dca_pkg::OFF_COUNT)
      |-> prdata[31:10] == 22'h0;
  endproperty
  a_count_read: assert property (p_count_read) else $error("count upper bits set");

  property p_block_wrap;
    @(posedge pclk) disable iff (!presetn)
    blk_end |=> st_reg.idx[$past(st_reg.cur)] == '0 && st_reg.fsm == dca_pkg::DCA_IDLE;
  endproperty
  a_block_wrap: assert property (p_block_wrap) else $error("block did not wrap");

  property p_pcoll_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_fire && paddr == dca_pkg::OFF_COLL) |=> (st_reg.pcoll & $past(st_reg.pcoll)) == $past(st_reg.pcoll);
  endproperty
  a_pcoll_hold: assert property (p_pcoll_hold) else $error("peripheral clash flag dropped");

  property p_rcoll_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_fire && paddr == dca_pkg::OFF_COLL) |=> (st_reg.rcoll & $past(st_reg.rcoll)) == $past(st_reg.rcoll);
  endproperty
  a_rcoll_hold: assert property (p_rcoll_hold) else $error("ram clash flag dropped");

  property p_last_update;
    @(posedge pclk) disable iff (!presetn)
    st_reg.fsm == dca_pkg::DCA_WR |=> st_reg.last == {1'b0, $past(st_reg.cur)} ##1 st_reg.last <= 4'h7;
  endproperty
  a_last_update: assert property (p_last_update) else $error("last channel wrong");

  property p_act_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == dca_pkg::OFF_ACT) |-> prdata[31:12] == 20'h0;
  endproperty
  a_act_read: assert property (p_act_read) else $error("activity upper bits set");

  property p_pingpong;
    @(posedge pclk) disable iff (!presetn)
    (blk_end && st_reg.ctrl[st_reg.cur].mode[1] && !wr_fire)
      |=> st_reg.pingpong_buffer_select[$past(st_reg.cur)] != $past(st_reg.pingpong_buffer_select[st_reg.cur]);
  endproperty
  a_pingpong: assert property (p_pingpong) else $error("ping-pong did not toggle");

  property p_recent;
    @(posedge pclk) disable iff (!presetn)
    st_reg.fsm == dca_pkg::DCA_WR
      |=> st_reg.recent == ($past(st_reg.wr.ram) ? $past(st_reg.wr.addr) : $past(st_reg.rd.addr));
  endproperty
  a_recent: assert property (p_recent) else $error("recent ram address wrong");

  property p_direction;
    @(posedge pclk) disable iff (!presetn)
    s_rd_phase |=> s_wr_opposite;
  endproperty
  a_direction: assert property (p_direction) else $error("write side not opposite of read");

  property p_done_irq;
    @(posedge pclk) disable iff (!presetn)
    (set_done != '0) |=> (st_reg.istat & $past(set_done)) == $past(set_done)
      && (irq || ($past(set_done) & st_reg.imask) == '0);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("block event not flagged");

  property p_clash;
    @(posedge pclk) disable iff (!presetn)
    clash |=> ((st_reg.pcoll | st_reg.rcoll) & $past(cur_oh)) != '0;
  endproperty
  a_clash: assert property (p_clash) else $error("clash not flagged");
endmodule // dca_core

// >>> dv/dca_periph_model.sv
// Purpose: peripheral and ram side seen by the dma mover
// Assumes: read data is returned in the cycle of the read strobe
// Notes:   outside a read the data lines carry the inverse of the last read value so stale values never match
module dca_periph_model (
  input  wire logic          pclk,
  input  wire logic [7:0]    fire,
  input  dca_pkg::dca_port_s rd_port,
  output logic [7:0]         dma_req,
  output logic [15:0]        rd_data
);
  logic [15:0] last = 16'h0000;
  assign dma_req = fire;
  // both spaces answer, so either direction setting gets data
  always_comb rd_data = rd_port.en ? (rd_port.addr ^ 16'h5a5a) : ~last;
  always @(posedge pclk) if (rd_port.en) last <= rd_data;
endmodule // dca_periph_model

// >>> dv/dca_core_tb_top.sv
// Purpose: self-checking bench of the dma address/count/status block
// Assumes: apb slave answers by pready; mover timing as in the hand-over
// Notes:   drivers queue expectations, monitors pop and compare them
module dca_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [7:0]         fire = 8'h00;
  logic [7:0]         dma_req;
  logic [15:0]        rd_data;
  logic               irq;
  logic [15:0]        p;
  dca_pkg::dca_cpu_s  cpu = '0;
  dca_pkg::dca_cpu_s  clash = '0;
  dca_pkg::dca_port_s rd_port;
  dca_pkg::dca_port_s wr_port;
  int                 mismatches = 0;
  int                 check_count = 0;
  logic [32:0]        apb_q[$];
  logic [32:0]        wr_q[$];

  always #50 pclk = ~pclk;

  dca_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_req(dma_req), .rd_data(rd_data), .cpu(cpu), .rd_port(rd_port), .wr_port(wr_port), .irq(irq));
  dca_periph_model peri_u (.pclk(pclk), .fire(fire), .rd_port(rd_port), .dma_req(dma_req),
    .rd_data(rd_data));

  function automatic void chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endfunction

  function automatic logic [7:0] ca(input int c, input logic [3:0] o);
    return {c[3:0], o};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0 && apb_q.size() == 0 && wr_q.size() == 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // apb and write-port monitor: error flag, read data and dma write against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready)
      chk("apb", apb_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    if (wr_port.en)
      chk("wr_port", wr_q.pop_front(), {wr_port.ram, wr_port.addr, wr_port.data});
  end

  // software write aimed at the cycle of the dma write
  always @(posedge pclk) cpu <= (rd_port.en && clash.wr) ? clash : '0;

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    apb_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed: only the watchdog ends a hung access
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic irqchk(input logic e);
    chk("irq", {32'h0, e}, {32'h0, irq});
  endtask

  // request timing is fixed by the mover: write strobe three cycles after the pulse
  task automatic xfer(input int c, input logic [32:0] e);
    wr_q.push_back(e);
    fire[c] <= 1'b1;
    @(posedge pclk);
    fire <= 8'h00;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    $display("watchdog expired");
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(32'hcf7f));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int c = 0; c < 8; c++) begin
      p = 16'($urandom);
      r(ca(c, dca_pkg::OFF_PADDR), 32'h0);
      r(ca(c, dca_pkg::OFF_COUNT), 32'h0);
      w(ca(c, dca_pkg::OFF_PADDR), {p, p});
      w(ca(c, dca_pkg::OFF_COUNT), {p, p});
      r(ca(c, dca_pkg::OFF_PADDR), {16'h0, p});
      r(ca(c, dca_pkg::OFF_COUNT), {22'h0, p[9:0]});
    end
    r(dca_pkg::OFF_COLL, 32'h0);
    w(dca_pkg::OFF_ACT, 32'hffff_ffff);
    r(dca_pkg::OFF_ACT, 32'h0000_0f00);
    r(dca_pkg::OFF_RECENT, 32'h0);
    apb(1'b0, 8'h94, 32'h0, {1'b1, 32'h0});
    $display("test registers done");
    w(dca_pkg::OFF_IMASK, 32'h4);
    for (int m = 0; m < 2; m++) begin
      p = 16'($urandom);
      w(ca(2, dca_pkg::OFF_CTRL), 32'h0);
      w(ca(2, dca_pkg::OFF_PADDR), {16'h0, p});
      w(ca(2, dca_pkg::OFF_COUNT), 32'h1);
      w(ca(2, dca_pkg::OFF_BASES), 32'h0200_0100);
      // second pass uses half-block events: two transfers, event after the first
      w(ca(2, dca_pkg::OFF_CTRL), m == 0 ? 32'h8000 : 32'h9001);
      for (int i = 0; i < 2; i++) begin
        clash = '{wr: m == 0 && i == 1, ram: 1'b1, addr: 16'h0100 + 16'(2 * i)};
        xfer(2, {1'b1, 16'h0100 + 16'(2 * i), p ^ 16'h5a5a});
        irqchk(i == 1 || m == 1);
      end
      clash.wr = 1'b0;
      r(dca_pkg::OFF_ACT, 32'h0000_0200);
      r(dca_pkg::OFF_RECENT, 32'h0000_0102);
      r(dca_pkg::OFF_COLL, m == 0 ? 32'h4 : 32'h0);
      w(dca_pkg::OFF_COLL, 32'hffff);
      r(dca_pkg::OFF_ISTAT, 32'h4);
      w(dca_pkg::OFF_ISTAT, 32'h4);
      r(ca(2, dca_pkg::OFF_CTRL), m == 0 ? 32'h8000 : 32'h1001);
      irqchk(1'b0);
    end
    $display("test block done");
    for (int m = 2; m < 4; m++) begin
      p = 16'($urandom);
      w(ca(5, dca_pkg::OFF_CTRL), 32'h0);
      w(ca(5, dca_pkg::OFF_PADDR), {16'h0, p});
      w(ca(5, dca_pkg::OFF_COUNT), 32'h0);
      w(ca(5, dca_pkg::OFF_BASES), 32'h0600_0400);
      w(ca(5, dca_pkg::OFF_CTRL), 32'ha000 | m);
      clash = '{wr: m == 2, ram: 1'b0, addr: p};
      xfer(5, {1'b0, p, 16'h0400 ^ 16'h5a5a});
      clash.wr = 1'b0;
      r(dca_pkg::OFF_ACT, 32'h0000_0520);
      r(dca_pkg::OFF_COLL, m == 2 ? 32'h2000 : 32'h0);
      w(dca_pkg::OFF_COLL, 32'hffff);
      xfer(5, {1'b0, p, 16'h0600 ^ 16'h5a5a});
      r(dca_pkg::OFF_ACT, 32'h0000_0500);
      r(dca_pkg::OFF_RECENT, 32'h0000_0600);
      r(dca_pkg::OFF_ISTAT, 32'h20);
      irqchk(1'b0);
      w(dca_pkg::OFF_ISTAT, 32'h20);
      r(ca(5, dca_pkg::OFF_CTRL), m == 2 ? 32'ha002 : 32'h2003);
    end
    $display("test ping-pong done");
    test_done();
  end
endmodule // dca_core_tb_top
